// ### prr_pkg.sv
// Shared constants and types for the pixel row/column readout block
package prr_pkg;
   localparam int ADDR_W = 10;
   localparam int CODE_W = 10;
   localparam logic [9:0] CODE_ALL_ONES = 10'h3FF;
   // Clock and converter timing
   localparam int CLK_MHZ = 40;
   localparam int ADC_VALID_NS = 20;
   localparam int ADC_VALID_RAW = (ADC_VALID_NS * CLK_MHZ) / 1000;
   localparam int ADC_VALID_CYC = (ADC_VALID_RAW < 1) ? 1 : ADC_VALID_RAW;
   localparam logic [2:0] ADC_CNT_LOAD = 3'(ADC_VALID_CYC);
   // Avalon register byte offsets
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_STATUS = 5'h04;
   localparam logic [4:0] OFF_ROW = 5'h08;
   localparam logic [4:0] OFF_COL = 5'h0C;
   localparam logic [4:0] OFF_CODE = 5'h10;
   localparam logic [4:0] OFF_ROWCNT = 5'h14;
   // Field positions
   localparam int CTRL_DS_EN = 0;
   localparam int ST_ROW_ACTIVE = 0;
   localparam int ST_PHASE_LO = 1;
   localparam int ST_PHASE_HI = 2;
   localparam int ST_COL_VALID = 3;
   localparam int ST_OUT_VALID = 4;
   localparam int ST_OUT_DIS = 5;
   // Reset values
   localparam logic CTRL_DS_EN_RST = 1'b0;
   localparam logic [9:0] ADDR_RST = 10'h000;
   localparam logic [15:0] ROWCNT_RST = 16'h0000;
   // Synchronised controller pins
   typedef struct packed {
      logic row_stb;
      logic col_stb;
      logic sig_smp;
      logic rst_smp;
      logic row_rst;
      logic ds_rst;
      logic cal;
      logic col_clk;
      logic adc_clk;
      logic inv_sel;
      logic out_dis;
   } prr_ctl_t;
   localparam int CTL_W = 11;
   localparam int SYNC_W = CTL_W + ADDR_W;
   // Drive towards the pixel array and column amplifiers
   typedef struct packed {
      logic [9:0] row;
      logic active;
      logic reset;
      logic ds_reset;
      logic sig_hold;
      logic rst_hold;
      logic cal;
   } prr_array_t;
   localparam prr_array_t ARRAY_RST = '{row: 10'h000, default: 1'b0};
   // Row sequence phase, Gray along the path
   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_SEL = 2'b01,
      PH_SIG = 2'b11,
      PH_DONE = 2'b10
   } prr_phase_t;
endpackage : prr_pkg

// ### prr_sync.sv
// Two-flop synchroniser bank for controller pins
`timescale 1ns/1ps
module prr_sync #(
   parameter int W = 1
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [W-1:0] D,
   output logic [W-1:0] Q
);
   logic [W-1:0] meta_q;
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         meta_q <= '0;
         Q <= '0;
      end else begin
         meta_q <= D;
         Q <= meta_q;
      end
   end
endmodule : prr_sync

// ### prr_readout.sv
// Row and column readout sequencer with converter output and Avalon status
// Functional notes
// R1 - Row address strobe latches shared address into the row decoder.
// R2 - Controller may present next address right after row latch.
// R3 - Latched row is selected and drives the column amplifiers.
// R4 - Signal sample, then row reset, then reset-level sample.
// R5 - After sampling, controller reads the row and may reset another.
// R6 - At least 3.6 us from row select to signal sample fall.
// R7 - Each sample pulse lasts at least 0.4 us.
// R8 - Row reset rises no earlier than signal sample fall.
// R9 - Row reset pulse lasts at least 200 ns.
// R10 - At least 1.6 us from row reset fall to reset sample fall.
// R11 - Row reset rises no earlier than row strobe fall.
// R12 - Row address held some time after row reset falls.
// R13 - Calibration pulse at least 100 ns after signal sample rises.
// R14 - Calibration pulse lasts at least 100 ns.
// R15 - Calibration pulse given once per frame.
// R16 - Column address latched on column strobe rising edge.
// R17 - Column shift clock loads column register and drives subtraction.
// R18 - First addressed pixel appears on third shift clock rising edge.
// R19 - Conversion starts on converter clock fall, data valid 20 ns later.
// R20 - Column shift clock runs whenever the sensor is powered.
// R21 - Inversion select low inverts the code; high passes it.
// R22 - Output disable high floats data pins; low drives them.
// R23 - Address bus line 0 is the most significant bit.
// R24 - Dual slope reset unused unless dual slope is wanted.
// R25 - Column readout starts after reset-level sample ends.
`timescale 1ns/1ps
module prr_readout (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [0:9] ADDR,
   input wire logic ROW_ADDRESS_STROBE,
   input wire logic COLUMN_ADDRESS_STROBE,
   input wire logic SIG_SAMPLE,
   input wire logic RST_SAMPLE,
   input wire logic ROW_RESET,
   input wire logic DUAL_SLOPE_RESET,
   input wire logic CAL_PULSE,
   input wire logic COL_SHIFT_CLK,
   input wire logic ADC_CLK,
   input wire logic CODE_INVERSION_SELECT,
   input wire logic OUTPUT_DISABLE,
   input wire logic [9:0] AMP_LEVEL,
   input wire logic [4:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output prr_pkg::prr_array_t ARRAY_O,
   output logic [9:0] COL_SELECT,
   output logic COL_SELECT_VALID,
   output logic [9:0] ANALOG_OUT,
   output logic [9:0] PIX_CODE_O,
   output logic PIX_CODE_OE
);
   localparam int ADC_DLY = prr_pkg::ADC_VALID_CYC;

   // Pin synchronisation, address line 0 lands in the top bit
   wire [prr_pkg::SYNC_W-1:0] pins_raw;
   logic [prr_pkg::SYNC_W-1:0] pins_s;
   assign pins_raw = {ROW_ADDRESS_STROBE, COLUMN_ADDRESS_STROBE, SIG_SAMPLE, RST_SAMPLE,
      ROW_RESET, DUAL_SLOPE_RESET, CAL_PULSE, COL_SHIFT_CLK, ADC_CLK,
      CODE_INVERSION_SELECT, OUTPUT_DISABLE, ADDR}; // R23

   prr_sync #(.W(prr_pkg::SYNC_W)) u_sync (
      .CLK(CLK),
      .RST_N(RST_N),
      .D(pins_raw),
      .Q(pins_s)
   );

   prr_pkg::prr_ctl_t ctl;
   prr_pkg::prr_ctl_t ctl_prev_q;
   wire [9:0] addr_s;
   assign ctl = pins_s[prr_pkg::SYNC_W-1:prr_pkg::ADDR_W];
   assign addr_s = pins_s[prr_pkg::ADDR_W-1:0];

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ctl_prev_q <= '0;
      end else begin
         ctl_prev_q <= ctl;
      end
   end

   // Edge events
   wire row_cap = ctl.row_stb & ~ctl_prev_q.row_stb;
   wire col_cap = ctl.col_stb & ~ctl_prev_q.col_stb;
   wire sig_fall = ~ctl.sig_smp & ctl_prev_q.sig_smp;
   wire rst_fall = ~ctl.rst_smp & ctl_prev_q.rst_smp;
   wire shift_rise = ctl.col_clk & ~ctl_prev_q.col_clk;
   wire adc_fall = ~ctl.adc_clk & ctl_prev_q.adc_clk;
   wire inv_s = ctl.inv_sel;

   // Software control
   logic ds_en_q;
   logic [15:0] rowcnt_q;

   // Row decoder and sample sequence
   logic [9:0] row_q;
   logic row_active_q;
   prr_pkg::prr_phase_t ph_q;
   prr_pkg::prr_phase_t ph_d;
   prr_pkg::prr_array_t array_q;
   prr_pkg::prr_array_t array_d;
   wire rst_hold = rst_fall & (ph_q == prr_pkg::PH_SIG);

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         row_q <= prr_pkg::ADDR_RST;
         row_active_q <= 1'b0;
         rowcnt_q <= prr_pkg::ROWCNT_RST;
      end else if (row_cap) begin
         row_q <= addr_s; // R1
         row_active_q <= 1'b1; // R3
         rowcnt_q <= rowcnt_q + 16'h0001;
      end
   end

   always_comb begin
      ph_d = ph_q;
      unique case (ph_q)
         prr_pkg::PH_IDLE: ph_d = ph_q;
         prr_pkg::PH_SEL: if (sig_fall) ph_d = prr_pkg::PH_SIG; // R4
         prr_pkg::PH_SIG: if (rst_fall) ph_d = prr_pkg::PH_DONE; // R4
         prr_pkg::PH_DONE: ph_d = ph_q;
      endcase
      if (row_cap) begin
         ph_d = prr_pkg::PH_SEL;
      end
   end

   always_comb begin
      array_d.row = row_q; // R3
      array_d.active = row_active_q;
      array_d.reset = ctl.row_rst;
      array_d.ds_reset = ctl.ds_rst & ds_en_q;
      array_d.sig_hold = sig_fall & (ph_q == prr_pkg::PH_SEL); // R4
      array_d.rst_hold = rst_hold; // R4
      array_d.cal = ctl.cal;
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ph_q <= prr_pkg::PH_IDLE;
         array_q <= prr_pkg::ARRAY_RST;
      end else begin
         ph_q <= ph_d;
         array_q <= array_d;
      end
   end
   assign ARRAY_O = array_q;

   // Column latch and three-stage shift pipeline
   logic [9:0] col_addr_q;
   logic col_loaded_q;
   logic [9:0] col_reg_q;
   logic col_reg_valid_q;
   logic [9:0] amp_q;
   logic amp_valid_q;
   logic [9:0] out_q;
   logic out_valid_q;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         col_addr_q <= prr_pkg::ADDR_RST;
         col_loaded_q <= 1'b0;
      end else if (col_cap) begin
         col_addr_q <= addr_s; // R16
         col_loaded_q <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         col_reg_q <= prr_pkg::ADDR_RST;
         col_reg_valid_q <= 1'b0;
         amp_q <= '0;
         amp_valid_q <= 1'b0;
         out_q <= '0;
         out_valid_q <= 1'b0;
      end else if (shift_rise) begin
         col_reg_q <= col_addr_q; // R17
         col_reg_valid_q <= col_loaded_q;
         amp_q <= AMP_LEVEL; // R17
         amp_valid_q <= col_reg_valid_q;
         out_q <= amp_q; // R18
         out_valid_q <= amp_valid_q;
      end
   end
   assign COL_SELECT = col_reg_q;
   assign COL_SELECT_VALID = col_reg_valid_q;
   assign ANALOG_OUT = out_q;

   // Converter: sample on clock fall, publish after the valid delay
   logic [9:0] smp_q;
   logic [2:0] adc_cnt_q;
   logic [9:0] code_q;
   wire adc_done = (adc_cnt_q == 3'h1);
   wire [9:0] code_d = inv_s ? smp_q : ~smp_q; // R21

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         smp_q <= '0;
         adc_cnt_q <= 3'h0;
         code_q <= prr_pkg::CODE_ALL_ONES;
      end else begin
         if (adc_fall) begin
            smp_q <= out_q; // R19
            adc_cnt_q <= prr_pkg::ADC_CNT_LOAD; // R19
         end else if (adc_cnt_q != 3'h0) begin
            adc_cnt_q <= adc_cnt_q - 3'h1;
         end
         if (adc_done) begin
            code_q <= code_d; // R21
         end
      end
   end
   assign PIX_CODE_O = code_q;
   assign PIX_CODE_OE = ~ctl.out_dis; // R22

   // Avalon slave, one wait state per access
   logic ack_q;
   logic [31:0] rdata_q;
   wire req = AVS_READ | AVS_WRITE;
   wire [31:0] status_w = {26'h0, ctl.out_dis, out_valid_q, col_loaded_q, ph_q,
      row_active_q};
   logic [31:0] rd_mux;

   always_comb begin
      unique case (AVS_ADDRESS)
         prr_pkg::OFF_CTRL: rd_mux = {31'h0, ds_en_q};
         prr_pkg::OFF_STATUS: rd_mux = status_w;
         prr_pkg::OFF_ROW: rd_mux = {22'h0, row_q};
         prr_pkg::OFF_COL: rd_mux = {22'h0, col_addr_q};
         prr_pkg::OFF_CODE: rd_mux = {22'h0, code_q};
         prr_pkg::OFF_ROWCNT: rd_mux = {16'h0, rowcnt_q};
         default: rd_mux = 32'h0;
      endcase
   end

   wire ctrl_wr = AVS_WRITE & ack_q & (AVS_ADDRESS == prr_pkg::OFF_CTRL) & AVS_BYTEENABLE[0];
   assign AVS_WAITREQUEST = req & ~ack_q;
   assign AVS_READDATA = rdata_q;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0;
         ds_en_q <= prr_pkg::CTRL_DS_EN_RST;
      end else begin
         ack_q <= req & ~ack_q;
         if (AVS_READ & ~ack_q) begin
            rdata_q <= rd_mux;
         end
         if (ctrl_wr) begin
            ds_en_q <= AVS_WRITEDATA[prr_pkg::CTRL_DS_EN];
         end
      end
   end

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_r1;
      row_cap |=> row_q == $past(addr_s);
   endproperty
   a_r1: assert property (p_r1) else $error("row address not latched"); // R1

   property p_r3;
      row_cap |-> ##2 (ARRAY_O.active && ARRAY_O.row == $past(addr_s, 2));
   endproperty
   a_r3: assert property (p_r3) else $error("latched row not selected"); // R3

   property p_r4_sig;
      (sig_fall && ph_q == prr_pkg::PH_SEL) |=> ARRAY_O.sig_hold ##1 !ARRAY_O.sig_hold;
   endproperty
   a_r4_sig: assert property (p_r4_sig) else $error("signal sample lost"); // R4

   property p_r4_order;
      ARRAY_O.rst_hold |-> (ph_q == prr_pkg::PH_DONE) && $past(ph_q, 2) == prr_pkg::PH_SIG;
   endproperty
   a_r4_order: assert property (p_r4_order) else $error("reset sample out of order"); // R4

   property p_r16;
      col_cap |=> col_addr_q == $past(addr_s)
         && ($past(shift_rise) || COL_SELECT == $past(COL_SELECT));
   endproperty
   a_r16: assert property (p_r16) else $error("column address not latched"); // R16

   property p_r17;
      shift_rise |=> COL_SELECT == $past(col_addr_q);
   endproperty
   a_r17: assert property (p_r17) else $error("column register not loaded"); // R17

   property p_r18;
      shift_rise |=> ANALOG_OUT == $past(amp_q) && amp_q == $past(AMP_LEVEL);
   endproperty
   a_r18: assert property (p_r18) else $error("analog output pipeline slip"); // R18

   property p_r19;
      (adc_fall && adc_cnt_q == 3'h0) |-> ##ADC_DLY adc_done;
   endproperty
   a_r19: assert property (p_r19) else $error("conversion not on time"); // R19

   property p_r21;
      adc_done |=> PIX_CODE_O == ($past(inv_s) ? $past(smp_q) : ~$past(smp_q));
   endproperty
   a_r21: assert property (p_r21) else $error("code inversion wrong"); // R21

   property p_r22;
      OUTPUT_DISABLE [*3] |-> !PIX_CODE_OE;
   endproperty
   a_r22: assert property (p_r22) else $error("data pins not released"); // R22

   c_row_done: cover property (ph_q == prr_pkg::PH_SIG ##[1:200] ph_q == prr_pkg::PH_DONE);
   c_first_px: cover property (col_cap ##[1:100] out_valid_q);
   c_convert: cover property (adc_fall ##ADC_DLY adc_done);
endmodule : prr_readout

// ### prr_ctl_model.sv
// Controller and column amplifier model driving the readout pins
`timescale 1ns/1ps
module prr_ctl_model (
   input wire logic clk,
   input wire logic [9:0] col_sel,
   output logic [0:9] addr,
   output prr_pkg::prr_ctl_t pin,
   output logic [9:0] amp
);
   logic [2:0] sh = 3'h0;
   initial begin
      pin = '0;
      addr = '0;
   end
   // Shift clock never stops, 4 high 4 low
   always @(posedge clk) begin
      sh <= sh + 3'h1;
      if (sh[1:0] == 2'h3) pin.col_clk <= ~sh[2];
   end
   assign amp = {col_sel[4:0], col_sel[9:5]} ^ 10'h15A;
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   task automatic row_seq(input logic [9:0] a, input logic c);
      @(posedge clk);
      addr <= a;
      pin.row_stb <= 1'b1;
      w(4);
      pin.row_stb <= 1'b0;
      w(126);
      pin.sig_smp <= 1'b1;
      w(8);
      pin.cal <= c;
      w(8);
      pin.sig_smp <= 1'b0;
      w(4);
      pin.row_rst <= 1'b1;
      w(8);
      pin.row_rst <= 1'b0;
      w(4);
      addr <= ~a;
      pin.cal <= 1'b0;
      w(44);
      pin.rst_smp <= 1'b1;
      w(16);
      pin.rst_smp <= 1'b0;
   endtask : row_seq
   task automatic lone_r();
      @(posedge clk);
      pin.row_rst <= 1'b1;
      w(8);
      pin.row_rst <= 1'b0;
      w(4);
      pin.rst_smp <= 1'b1;
      w(16);
      pin.rst_smp <= 1'b0;
      w(8);
   endtask : lone_r
   task automatic col_ld(input logic [9:0] a);
      @(posedge clk);
      while (sh != 3'h7) @(negedge clk);
      @(posedge clk);
      addr <= a;
      pin.col_stb <= 1'b1;
      w(4);
      pin.col_stb <= 1'b0;
      addr <= ~a;
   endtask : col_ld
   task automatic adc();
      @(posedge clk);
      pin.adc_clk <= 1'b1;
      w(4);
      pin.adc_clk <= 1'b0;
      w(10);
   endtask : adc
   task automatic lv(input logic inv, input logic od, input logic ds);
      @(posedge clk);
      pin.inv_sel <= inv;
      pin.out_dis <= od;
      pin.ds_rst <= ds;
      w(6);
   endtask : lv
endmodule : prr_ctl_model

// ### prr_readout_test.sv
// Self-checking bench for the pixel row and column readout block
`timescale 1ns/1ps
module prr_readout_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] av_a = 5'h00;
   logic av_rd = 1'b0;
   logic av_wr = 1'b0;
   logic [31:0] av_wd = 32'h0;
   logic [3:0] av_be = 4'hF;
   logic [31:0] av_q, rdata;
   logic wait_req, col_v, code_oe, cal_q, rr_q;
   logic [0:9] addr;
   logic [9:0] amp, col_sel, ana, code;
   prr_pkg::prr_ctl_t pin;
   prr_pkg::prr_array_t arr;
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   int n_sig = 0, n_rst = 0, n_cal = 0, n_rr = 0;
   integer seed = 32'h8e0e;
   always #12.5 clk = ~clk;
   prr_ctl_model pm (.clk(clk), .col_sel(col_sel), .addr(addr), .pin(pin), .amp(amp));
   prr_readout dut (
      .CLK(clk), .RST_N(rst_n), .ADDR(addr), .ROW_ADDRESS_STROBE(pin.row_stb),
      .COLUMN_ADDRESS_STROBE(pin.col_stb), .SIG_SAMPLE(pin.sig_smp), .RST_SAMPLE(pin.rst_smp),
      .ROW_RESET(pin.row_rst), .DUAL_SLOPE_RESET(pin.ds_rst), .CAL_PULSE(pin.cal),
      .COL_SHIFT_CLK(pin.col_clk), .ADC_CLK(pin.adc_clk), .CODE_INVERSION_SELECT(pin.inv_sel),
      .OUTPUT_DISABLE(pin.out_dis), .AMP_LEVEL(amp), .AVS_ADDRESS(av_a), .AVS_READ(av_rd),
      .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_q),
      .AVS_WAITREQUEST(wait_req), .ARRAY_O(arr), .COL_SELECT(col_sel),
      .COL_SELECT_VALID(col_v), .ANALOG_OUT(ana), .PIX_CODE_O(code), .PIX_CODE_OE(code_oe)
   );
   // Pulse and edge counters on the array drive
   always @(posedge clk) begin
      cyc <= cyc + 1;
      cal_q <= arr.cal;
      rr_q <= arr.reset;
      if (arr.sig_hold === 1'b1) n_sig <= n_sig + 1;
      if (arr.rst_hold === 1'b1) n_rst <= n_rst + 1;
      if (arr.cal === 1'b1 && cal_q === 1'b0) n_cal <= n_cal + 1;
      if (arr.reset === 1'b1 && rr_q === 1'b0) n_rr <= n_rr + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   function automatic logic [9:0] amp_of(input logic [9:0] c);
      return {c[4:0], c[9:5]} ^ 10'h15A;
   endfunction : amp_of
   task automatic give_verdict();
      if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic chk_c(input logic [9:0] g, input logic [9:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t code %h exp %h", $time, g, e);
      end
   endtask : chk_c
   task automatic chk_b(input logic g, input logic e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t flag %b exp %b", $time, g, e);
      end
   endtask : chk_b
   task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t word %h exp %h", $time, g, e);
      end
   endtask : chk_w
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge clk);
      av_a <= a;
      av_wd <= d;
      av_be <= b;
      av_wr <= w;
      av_rd <= ~w;
      @(posedge clk);
      while (wait_req !== 1'b0) begin
         n++;
         @(posedge clk);
      end
      rdata = av_q;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      chk_w(32'(n), 32'h1);
   endtask : av
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      av(1'b0, a, 32'h0, 4'hF);
      chk_w(rdata, e);
   endtask : rd
   initial begin
      logic [9:0] a, c, pc, e;
      logic inv;
      pc = 10'h000;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk_c(code, 10'h3FF);
      chk_b(code_oe, 1'b1);
      chk_b(arr.active, 1'b0);
      rd(prr_pkg::OFF_CTRL, 32'h0);
      av(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
      rd(5'h18, 32'h0);
      av(1'b1, prr_pkg::OFF_ROW, 32'h3FF, 4'hF);
      rd(prr_pkg::OFF_ROW, 32'h0);
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 10'h200 : 10'($random(seed));
         pm.row_seq(a, i == 0);
         repeat (6) @(posedge clk);
         @(negedge clk);
         chk_c(arr.row, a);
         chk_b(arr.active, 1'b1);
         chk_w(32'(n_sig), 32'(i + 1));
         chk_w(32'(n_rst), 32'(i + 1));
         chk_w(32'(n_rr), 32'(i + 1));
         rd(prr_pkg::OFF_ROW, {22'h0, a});
      end
      chk_w(32'(n_cal), 32'h1);
      rd(prr_pkg::OFF_ROWCNT, 32'h6);
      rd(prr_pkg::OFF_STATUS, 32'h5);
      pm.lone_r();
      chk_w(32'(n_rst), 32'h6);
      chk_w(32'(n_rr), 32'h7);
      for (int i = 0; i < 6; i++) begin
         c = (i == 0) ? 10'h3FF : 10'($random(seed));
         if (c == pc) c = ~pc;
         pm.col_ld(c);
         repeat (14) @(posedge clk);
         @(negedge clk);
         chk_c(ana, amp_of(pc));
         repeat (8) @(posedge clk);
         @(negedge clk);
         chk_c(col_sel, c);
         chk_b(col_v, 1'b1);
         chk_c(ana, amp_of(c));
         rd(prr_pkg::OFF_COL, {22'h0, c});
         inv = (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : 1'($random(seed));
         pm.lv(inv, 1'b0, 1'b0);
         pm.adc();
         @(negedge clk);
         e = inv ? amp_of(c) : ~amp_of(c);
         chk_c(code, e);
         rd(prr_pkg::OFF_CODE, {22'h0, e});
         pc = c;
      end
      pm.lv(1'b1, 1'b1, 1'b1);
      @(negedge clk);
      chk_b(code_oe, 1'b0);
      chk_b(arr.ds_reset, 1'b0);
      av(1'b1, prr_pkg::OFF_CTRL, 32'h1, 4'hE);
      rd(prr_pkg::OFF_CTRL, 32'h0);
      av(1'b1, prr_pkg::OFF_CTRL, 32'h1, 4'h1);
      rd(prr_pkg::OFF_CTRL, 32'h1);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk_b(arr.ds_reset, 1'b1);
      pm.lv(1'b1, 1'b0, 1'b0);
      @(negedge clk);
      chk_b(code_oe, 1'b1);
      chk_b(arr.ds_reset, 1'b0);
      give_verdict();
   end
endmodule : prr_readout_test
